// file: core/pllcfg_top.sv
// loop configuration block: pre-divider, multiplier and filter registers plus lock flag
// assumes a single-cycle register write port and a raw lock indication from the analog loop
// the analog loop, its reference source and the loop enable register live outside
//
// Contract
// - nonzero pre-divide code divides by that code
// - zero pre-divide code divides by thirty-two
// - pre-divider upper three bits read zero
// - nonzero multiplier code multiplies by that code
// - zero multiplier code multiplies by 256
// - filter register upper two bits read zero
// - output equals reference times multiplier over divider
// - lock flag set once loop stable
// - disabled loop held in reset, no lock
`timescale 1ns/10ps
module pllcfg_top #(
	parameter int LOCK_STABLE_CYCLES = pllcfg_pkg::PLLCFG_LOCK_STABLE_CYC
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// register port
	input wire pllcfg_pkg::pllcfg_sfr_s SFR_REQ_I,
	output logic [7:0] SFR_RDATA_O,
	// loop control and status
	input wire logic LOOP_RUN_ENABLE_I,
	input wire logic LOOP_LOCK_DET_I,
	output logic LOOP_RESET_O,
	output logic LOCK_FLAG_O,
	// effective settings to the analog loop
	output pllcfg_pkg::pllcfg_cfg_s CFG_O
);
	// reset copy, stored fields and output flops
	logic rst_meta_r, rst_sync_r;
	logic [pllcfg_pkg::PLLCFG_DIV_W-1:0] ref_predivide_code_r;
	logic [pllcfg_pkg::PLLCFG_MULT_W-1:0] loop_mult_code_r;
	logic [pllcfg_pkg::PLLCFG_FILT_W-1:0] filt_r;
	logic [7:0] rdata_r;
	logic loop_reset_r;
	pllcfg_pkg::pllcfg_cfg_s cfg_r;
	logic lock_flag;

	// ********************************************************
	// reset release
	// ********************************************************
	// assertion is immediate, release waits two edges to avoid metastable recovery
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ********************************************************
	// register decode
	// ********************************************************
	wire hit_div = SFR_REQ_I.addr == pllcfg_pkg::PLLCFG_ADDR_PREDIV;
	wire hit_mult = SFR_REQ_I.addr == pllcfg_pkg::PLLCFG_ADDR_MULT;
	wire hit_filt = SFR_REQ_I.addr == pllcfg_pkg::PLLCFG_ADDR_FILT;
	wire wr_div = SFR_REQ_I.wr && hit_div;
	wire wr_mult = SFR_REQ_I.wr && hit_mult;
	wire wr_filt = SFR_REQ_I.wr && hit_filt;
	// any new setting invalidates a reported lock
	wire cfg_wr = wr_div || wr_mult || wr_filt;

	// read mux; unused upper bits are zero-extended
	wire [7:0] rd_div = {3'h0, ref_predivide_code_r};
	wire [7:0] rd_filt = {2'h0, filt_r};
	wire [7:0] rd_nxt = hit_div ? rd_div :
		hit_mult ? loop_mult_code_r :
		hit_filt ? rd_filt : pllcfg_pkg::PLLCFG_RD_UNMAPPED;

	// ********************************************************
	// configuration registers
	// ********************************************************
	// only the implemented field bits are stored, so upper written bits are dropped
	always_ff @(posedge CLK_I or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ref_predivide_code_r <= pllcfg_pkg::PLLCFG_RST_PREDIV[pllcfg_pkg::PLLCFG_DIV_W-1:0];
			loop_mult_code_r <= pllcfg_pkg::PLLCFG_RST_MULT;
			filt_r <= pllcfg_pkg::PLLCFG_RST_FILT[pllcfg_pkg::PLLCFG_FILT_W-1:0];
		end else begin
			if (wr_div) begin
				ref_predivide_code_r <= SFR_REQ_I.wdata[pllcfg_pkg::PLLCFG_DIV_W-1:0];
			end
			if (wr_mult) begin
				loop_mult_code_r <= SFR_REQ_I.wdata;
			end
			if (wr_filt) begin
				filt_r <= SFR_REQ_I.wdata[pllcfg_pkg::PLLCFG_FILT_W-1:0];
			end
		end
	end

	// ********************************************************
	// effective ratios
	// ********************************************************
	// zero codes select the largest ratio; outside reset the analog loop never sees a zero
	wire [5:0] div_eff = (ref_predivide_code_r == '0) ? pllcfg_pkg::PLLCFG_DIV_ZERO_EFF :
		{1'b0, ref_predivide_code_r};
	wire [8:0] mult_eff = (loop_mult_code_r == '0) ? pllcfg_pkg::PLLCFG_MULT_ZERO_EFF :
		{1'b0, loop_mult_code_r};
	// range codes pass through as written; picking them right is software's job
	wire [1:0] osc_range_sel = filt_r[pllcfg_pkg::PLLCFG_OSC_LSB +: 2];
	wire [3:0] loop_filter_sel = filt_r[pllcfg_pkg::PLLCFG_LPF_W-1:0];

	// ********************************************************
	// output registers
	// ********************************************************
	// the loop produces reference * mult_eff / div_eff from these values
	always_ff @(posedge CLK_I or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			cfg_r <= '0;
			rdata_r <= pllcfg_pkg::PLLCFG_RD_UNMAPPED;
			loop_reset_r <= 1'b1;
		end else begin
			cfg_r <= '{div: div_eff, mult: mult_eff, osc: osc_range_sel, lpf: loop_filter_sel};
			rdata_r <= rd_nxt;
			loop_reset_r <= !LOOP_RUN_ENABLE_I;
		end
	end

	// lock qualifier
	pllcfg_lock #(
		.STABLE_CYC(LOCK_STABLE_CYCLES)
	) u_lock (
		.clk_i(CLK_I),
		.rst_n_i(rst_sync_r),
		.enable_i(LOOP_RUN_ENABLE_I),
		.restart_i(cfg_wr),
		.det_i(LOOP_LOCK_DET_I),
		.locked_o(lock_flag)
	);

	// every port comes straight from a flop
	assign SFR_RDATA_O = rdata_r;
	assign LOOP_RESET_O = loop_reset_r;
	assign LOCK_FLAG_O = lock_flag;
	assign CFG_O = cfg_r;

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!rst_sync_r);

	// pre-divide mapping, seen two edges after the strobe
	div_zero_map_a: assert property (wr_div && SFR_REQ_I.wdata[4:0] == 5'h00 |=> ##1 CFG_O.div == 6'h20)
		else $error("zero pre-divide code not mapped to 32");
	div_code_map_a: assert property (wr_div && SFR_REQ_I.wdata[4:0] != 5'h00
		|=> ##1 CFG_O.div == {1'b0, $past(SFR_REQ_I.wdata[4:0], 2)})
		else $error("pre-divide code not passed through");
	// unused register bits never show on the read port
	div_upper_zero_a: assert property (SFR_REQ_I.addr == 8'h8D && !SFR_REQ_I.wr |=> SFR_RDATA_O[7:5] == 3'h0)
		else $error("pre-divider upper bits not zero");
	// multiplier mapping, zero meaning the largest factor
	mult_map_a: assert property (wr_mult |=> ##1
		CFG_O.mult == (($past(SFR_REQ_I.wdata, 2) == 8'h00) ? 9'h100 : {1'b0, $past(SFR_REQ_I.wdata, 2)}))
		else $error("multiplier mapping wrong");
	filt_upper_zero_a: assert property (SFR_REQ_I.addr == 8'h8F |=> SFR_RDATA_O[7:6] == 2'h0)
		else $error("filter upper bits not zero");
	// range fields reach the loop unchanged
	filt_fields_a: assert property (wr_filt |=> ##1
		CFG_O.osc == $past(SFR_REQ_I.wdata[5:4], 2) && CFG_O.lpf == $past(SFR_REQ_I.wdata[3:0], 2))
		else $error("filter fields not forwarded");
	// loop reset and lock follow the enable level
	disabled_reset_a: assert property (!LOOP_RUN_ENABLE_I |=> LOOP_RESET_O && !LOCK_FLAG_O)
		else $error("disabled loop not held in reset");
	disable_clears_a: assert property ($fell(LOOP_RUN_ENABLE_I) |-> ##1 !LOCK_FLAG_O [*2])
		else $error("lock not cleared on disable");


	// ********************************************************
	// read-back and lock checks
	// ********************************************************
	// a written value reads back, unused upper bits as zero, once its address is shown again
	div_readback_a: assert property (wr_div ##1 hit_div
		|=> SFR_RDATA_O == {3'h0, $past(SFR_REQ_I.wdata[4:0], 2)})
		else $error("pre-divider read-back wrong");
	mult_readback_a: assert property (wr_mult ##1 hit_mult
		|=> SFR_RDATA_O == $past(SFR_REQ_I.wdata, 2))
		else $error("multiplier read-back wrong");
	filt_readback_a: assert property (wr_filt ##1 hit_filt
		|=> SFR_RDATA_O == {2'h0, $past(SFR_REQ_I.wdata[5:0], 2)})
		else $error("filter read-back wrong");
	// without a write the settings seen by the loop must not move; the reset edge is left out
	cfg_hold_a: assert property (rst_sync_r && !cfg_wr |=> ##1 $stable(CFG_O))
		else $error("settings changed without a write");
	// the flag only rises with detector and enable both high a full settle count earlier
	lock_settled_a: assert property ($rose(LOCK_FLAG_O) |->
		$past(LOOP_LOCK_DET_I, LOCK_STABLE_CYCLES) && $past(LOOP_RUN_ENABLE_I, LOCK_STABLE_CYCLES))
		else $error("lock rose before the settle count");
	// a held lock stays while nothing disturbs it
	lock_holds_a: assert property (LOCK_FLAG_O && LOOP_LOCK_DET_I
		&& LOOP_RUN_ENABLE_I && !cfg_wr |=> LOCK_FLAG_O)
		else $error("lock lost without cause");
	// detector dropout seen on the port
	det_drop_a: assert property (LOCK_FLAG_O && !LOOP_LOCK_DET_I |=> !LOCK_FLAG_O)
		else $error("lock kept after detector dropout");
	// a new setting invalidates the reported lock at once
	write_drops_lock_a: assert property (cfg_wr |=> !LOCK_FLAG_O)
		else $error("lock kept across a setting change");
	// lock and loop reset are never shown together
	lock_run_excl_a: assert property (LOCK_FLAG_O |-> !LOOP_RESET_O)
		else $error("lock reported while loop held in reset");
	lock_needs_run_a: assert property ($rose(LOCK_FLAG_O) |-> !$past(LOOP_RESET_O))
		else $error("lock rose while loop held in reset");
	enable_release_a: assert property (rst_sync_r && LOOP_RUN_ENABLE_I |=> !LOOP_RESET_O)
		else $error("enabled loop still held in reset");

	// main scenarios worth seeing at least once
	cfg_write_c: cover property (wr_mult ##1 wr_div ##1 wr_filt);
	lock_after_en_c: cover property ($rose(LOOP_RUN_ENABLE_I) ##[1:100] $rose(LOCK_FLAG_O));
	zero_codes_c: cover property (CFG_O.div == 6'h20 && CFG_O.mult == 9'h100);
	relock_c: cover property ($fell(LOCK_FLAG_O) ##[1:30] $rose(LOCK_FLAG_O));
endmodule // pllcfg_top

// file: core/pllcfg_pkg.sv
// constants, types and register map of the loop configuration block
// assumes a 200 MHz system clock and an 8-bit special-function register port
package pllcfg_pkg;
	// ********************************************************
	// register map and values after reset
	// ********************************************************
	localparam logic [7:0] PLLCFG_ADDR_PREDIV = 8'h8D;
	localparam logic [7:0] PLLCFG_ADDR_MULT = 8'h8E;
	localparam logic [7:0] PLLCFG_ADDR_FILT = 8'h8F;
	localparam logic [7:0] PLLCFG_RST_PREDIV = 8'h01;
	localparam logic [7:0] PLLCFG_RST_MULT = 8'h01;
	localparam logic [7:0] PLLCFG_RST_FILT = 8'h31;
	localparam logic [7:0] PLLCFG_RD_UNMAPPED = 8'h00;

	// ********************************************************
	// field layout
	// ********************************************************
	localparam int PLLCFG_DIV_W = 5;
	localparam int PLLCFG_MULT_W = 8;
	localparam int PLLCFG_FILT_W = 6;
	localparam int PLLCFG_OSC_LSB = 4;
	localparam int PLLCFG_LPF_W = 4;
	localparam logic [5:0] PLLCFG_DIV_ZERO_EFF = 6'h20;
	localparam logic [8:0] PLLCFG_MULT_ZERO_EFF = 9'h100;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int PLLCFG_CLK_PERIOD_PS = 5000;
	localparam int PLLCFG_LOCK_STABLE_NS = 100;
	// least time, rounded up to whole cycles
	localparam int PLLCFG_LOCK_STABLE_CYC =
		(PLLCFG_LOCK_STABLE_NS * 1000 + PLLCFG_CLK_PERIOD_PS - 1) / PLLCFG_CLK_PERIOD_PS;
	localparam int PLLCFG_CNT_W = 8;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		PLLCFG_IDLE = 2'b00,
		PLLCFG_SETTLE = 2'b01,
		PLLCFG_LOCKED = 2'b10
	} pllcfg_lock_e;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pllcfg_sfr_s;

	typedef struct packed {
		logic [5:0] div;
		logic [8:0] mult;
		logic [1:0] osc;
		logic [3:0] lpf;
	} pllcfg_cfg_s;
endpackage

// file: core/pllcfg_lock.sv
// lock qualifier: turns the raw phase-detector lock indication into a stable flag
// assumes the detector input is synchronous to the clock
`timescale 1ns/10ps
module pllcfg_lock #(
	parameter int STABLE_CYC = pllcfg_pkg::PLLCFG_LOCK_STABLE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic enable_i,
	input wire logic restart_i,
	input wire logic det_i,
	// status
	output logic locked_o
);
	localparam logic [pllcfg_pkg::PLLCFG_CNT_W-1:0] LAST = pllcfg_pkg::PLLCFG_CNT_W'(STABLE_CYC - 1);

	pllcfg_pkg::pllcfg_lock_e state_r, state_nxt;
	logic [pllcfg_pkg::PLLCFG_CNT_W-1:0] cnt_r, cnt_nxt;
	logic locked_r;

	// ********************************************************
	// settle sequencing
	// ********************************************************
	// any dropout of the detector restarts the stable count, so a glitchy lock never reports
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			pllcfg_pkg::PLLCFG_IDLE: begin
				cnt_nxt = '0;
				if (enable_i && !restart_i) begin
					state_nxt = pllcfg_pkg::PLLCFG_SETTLE;
				end
			end
			pllcfg_pkg::PLLCFG_SETTLE: begin
				if (!det_i) begin
					cnt_nxt = '0;
				end else if (cnt_r == LAST) begin
					state_nxt = pllcfg_pkg::PLLCFG_LOCKED;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			pllcfg_pkg::PLLCFG_LOCKED: begin
				if (!det_i) begin
					state_nxt = pllcfg_pkg::PLLCFG_SETTLE;
					cnt_nxt = '0;
				end
			end
			default: begin
				state_nxt = pllcfg_pkg::PLLCFG_IDLE;
			end
		endcase
		// leaving enable or a new setting wins over everything
		if (!enable_i || restart_i) begin
			state_nxt = pllcfg_pkg::PLLCFG_IDLE;
			cnt_nxt = '0;
		end
	end

	// state registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= pllcfg_pkg::PLLCFG_IDLE;
			cnt_r <= '0;
			locked_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			locked_r <= (state_nxt == pllcfg_pkg::PLLCFG_LOCKED);
		end
	end

	assign locked_o = locked_r;

	// ********************************************************
	// checks
	// ********************************************************
	lock_needs_det_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(locked_r) |-> $past(det_i) && $past(enable_i))
		else $error("lock rose without detector or enable");
	lock_drops_det_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		locked_r && !det_i |=> !locked_r)
		else $error("lock held after detector dropout");
	lock_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		restart_i |=> !locked_r ##1 !locked_r)
		else $error("lock reported too soon after restart");
	lock_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(locked_r));
endmodule // pllcfg_lock

// file: tb/tb_top.sv
// self-checking bench for the loop configuration block
// assumes the block alone, driven on its own ports with a shortened lock count
`timescale 1ns/10ps
module tb_top;
	// ********************************************************
	// clock, reset, stimulus and counters
	// ********************************************************
	localparam int LOCK_N = 4;
	logic CLK_I = 1'b0;
	logic ARST_N_I = 1'b0;
	pllcfg_pkg::pllcfg_sfr_s SFR_REQ_I = '0;
	logic LOOP_RUN_ENABLE_I = 1'b0;
	logic LOOP_LOCK_DET_I = 1'b0;
	logic [7:0] SFR_RDATA_O;
	logic LOOP_RESET_O;
	logic LOCK_FLAG_O;
	pllcfg_pkg::pllcfg_cfg_s CFG_O;
	int bad_count = 0;
	int check_count = 0;
	int seed = 57752;
	logic [7:0] pd_m = 8'h01;
	logic [7:0] ml_m = 8'h01;
	logic [7:0] fl_m = 8'h31;
	pllcfg_top #(.LOCK_STABLE_CYCLES(LOCK_N)) u_pllcfg_top (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
		.SFR_REQ_I(SFR_REQ_I), .SFR_RDATA_O(SFR_RDATA_O), .LOOP_RUN_ENABLE_I(LOOP_RUN_ENABLE_I),
		.LOOP_LOCK_DET_I(LOOP_LOCK_DET_I), .LOOP_RESET_O(LOOP_RESET_O), .LOCK_FLAG_O(LOCK_FLAG_O),
		.CFG_O(CFG_O));
	// 200 MHz clock
	initial begin
		forever #2.5 CLK_I = ~CLK_I;
	end
	// ********************************************************
	// expectation, compare and bus tasks
	// ********************************************************
	// effective settings from the register model; zero codes mean the largest ratio
	function automatic pllcfg_pkg::pllcfg_cfg_s exp_cfg();
		pllcfg_pkg::pllcfg_cfg_s c;
		c.div = (pd_m[4:0] == 5'h00) ? pllcfg_pkg::PLLCFG_DIV_ZERO_EFF : {1'b0, pd_m[4:0]};
		c.mult = (ml_m == 8'h00) ? pllcfg_pkg::PLLCFG_MULT_ZERO_EFF : {1'b0, ml_m};
		c.osc = fl_m[5:4];
		c.lpf = fl_m[3:0];
		return c;
	endfunction
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cfg(input pllcfg_pkg::pllcfg_cfg_s got, input pllcfg_pkg::pllcfg_cfg_s exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected settings at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe; register takes it at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		SFR_REQ_I <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge CLK_I);
		SFR_REQ_I.wr <= 1'b0;
	endtask
	// read data is registered, so look one edge after the address lands
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK_I);
		SFR_REQ_I.addr <= a;
		@(posedge CLK_I);
		#1 chk8(SFR_RDATA_O, exp);
	endtask
	// update model, write, read back masked, then check effective settings
	task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
		if (a == pllcfg_pkg::PLLCFG_ADDR_PREDIV) pd_m = {3'b000, d[4:0]};
		if (a == pllcfg_pkg::PLLCFG_ADDR_MULT) ml_m = d;
		if (a == pllcfg_pkg::PLLCFG_ADDR_FILT) fl_m = {2'b00, d[5:0]};
		wr(a, d);
		rd(a, (a == pllcfg_pkg::PLLCFG_ADDR_PREDIV) ? pd_m : (a == pllcfg_pkg::PLLCFG_ADDR_MULT) ? ml_m : fl_m);
		chk_cfg(CFG_O, exp_cfg());
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ********************************************************
	// watchdog and main sequence
	// ********************************************************
	initial begin
		#(5 * 20000);
		bad_count++;
		conclude();
	end
	initial begin : main_seq
		logic [7:0] corner_a [6];
		logic [7:0] corner_d [6];
		int n;
		corner_a = '{8'h8D, 8'h8D, 8'h8E, 8'h8E, 8'h8F, 8'h8F};
		corner_d = '{8'hE0, 8'hFF, 8'h00, 8'hFF, 8'hC0, 8'hFF};
		repeat (6) @(posedge CLK_I);
		ARST_N_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		#1 chk_cfg(CFG_O, exp_cfg());
		chk1(LOOP_RESET_O, 1'b1);
		rd(pllcfg_pkg::PLLCFG_ADDR_PREDIV, pllcfg_pkg::PLLCFG_RST_PREDIV);
		rd(pllcfg_pkg::PLLCFG_ADDR_MULT, pllcfg_pkg::PLLCFG_RST_MULT);
		rd(pllcfg_pkg::PLLCFG_ADDR_FILT, pllcfg_pkg::PLLCFG_RST_FILT);
		// zero codes, full codes and dropped upper bits
		for (int i = 0; i < 6; i++) wr_chk(corner_a[i], corner_d[i]);
		// unmapped place: reads zero, write has no effect
		wr(8'h90, 8'h55);
		rd(8'h8C, pllcfg_pkg::PLLCFG_RD_UNMAPPED);
		chk_cfg(CFG_O, exp_cfg());
		for (int i = 0; i < 24; i++) wr_chk(8'h8D + 8'(i % 3), 8'($random(seed)));
		// legal setting before enabling: 25 MHz reference, 50 MHz out, matching range codes
		wr_chk(pllcfg_pkg::PLLCFG_ADDR_PREDIV, 8'h01);
		wr_chk(pllcfg_pkg::PLLCFG_ADDR_MULT, 8'h02);
		wr_chk(pllcfg_pkg::PLLCFG_ADDR_FILT, 8'h31);
		// det ignored while loop disabled
		@(posedge CLK_I);
		LOOP_LOCK_DET_I <= 1'b1;
		repeat (10) @(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b0);
		// lock after the settle count, then loss on det low
		@(posedge CLK_I);
		LOOP_RUN_ENABLE_I <= 1'b1;
		repeat (LOCK_N) @(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b0);
		n = 0;
		while (LOCK_FLAG_O !== 1'b1 && n < 20) begin
			@(posedge CLK_I);
			#1 n++;
		end
		chk1(LOCK_FLAG_O, 1'b1);
		chk1(LOOP_RESET_O, 1'b0);
		@(posedge CLK_I);
		LOOP_LOCK_DET_I <= 1'b0;
		@(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b0);
		// relock, then leave enabled state
		@(posedge CLK_I);
		LOOP_LOCK_DET_I <= 1'b1;
		repeat (LOCK_N + 4) @(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b1);
		// a new setting while locked drops the flag, then the loop settles again
		wr_chk(pllcfg_pkg::PLLCFG_ADDR_FILT, 8'h31);
		chk1(LOCK_FLAG_O, 1'b0);
		repeat (LOCK_N + 4) @(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b1);
		@(posedge CLK_I);
		LOOP_RUN_ENABLE_I <= 1'b0;
		@(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b0);
		chk1(LOOP_RESET_O, 1'b1);
		repeat (LOCK_N + 4) @(posedge CLK_I);
		#1 chk1(LOCK_FLAG_O, 1'b0);
		conclude();
	end
endmodule // tb_top
